// ### rtl/rsfm_top.v
// rsfm_top.v: rail sequencing and fault manager with AXI4-Lite slave
// assumes synchronous inputs on i_sys_clk, measurement words from the
// digital sense path, and a power-on reset on i_rst
//
// Function
// RQ1: after reset load selected config, thresholds, start telemetry
// RQ2: wait in shutdown until rail enable requests start
// RQ3: phase outputs high impedance during shutdown
// RQ4: programmable delay then programmable ramp, ramp down too
// RQ5: about 200 us initialization before ramp begins
// RQ6: zero ramp setting steps straight to target
// RQ7: select resistance code maps to configuration identifier
// RQ8: newest save per identifier loads, eight saves total; code records saves per id but loads no saved configuration after reset
// RQ9: each fault enable and latch or retry
// RQ10: rail good only after ramp and in window
// RQ11: rail good masks faults, low on OC OV UV
// RQ12: digital compare of sensed output against thresholds
// RQ13: overvoltage: off, fault, alert, low side pulsing
// RQ14: undervoltage: off, fault, alert, rail good low
// RQ15: latched fault holds until enable cycles
// RQ16: open sense suspends controller
// RQ17: fast and slow total overcurrent, no pwm effect
// RQ18: phase peak overcurrent inverts that phase pwm
// RQ19: peak limit forever or fault after count
// RQ20: sense beyond full scale shuts rail immediately
// RQ21: thermal warning valid only when enabled, warning only
// RQ22: warning and fault temperature thresholds, maskable
// RQ23: one sequencer instance per rail
`timescale 1ns/10ps
`include "rsfm_regs.vh"
module rsfm_top #(
   parameter NRAIL = 2,
   parameter NPH = 2,
   parameter INIT_CYC = `RSFM_INIT_CYC
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire [7:0] i_s_axi_awaddr,
   input wire i_s_axi_awvalid,
   output wire o_s_axi_awready,
   input wire [31:0] i_s_axi_wdata,
   input wire [3:0] i_s_axi_wstrb,
   input wire i_s_axi_wvalid,
   output wire o_s_axi_wready,
   output wire [1:0] o_s_axi_bresp,
   output wire o_s_axi_bvalid,
   input wire i_s_axi_bready,
   input wire [7:0] i_s_axi_araddr,
   input wire i_s_axi_arvalid,
   output wire o_s_axi_arready,
   output wire [31:0] o_s_axi_rdata,
   output wire [1:0] o_s_axi_rresp,
   output wire o_s_axi_rvalid,
   input wire i_s_axi_rready,
   input wire [2:0] i_cfg_sel_code,
   input wire i_input_voltage_ok,
   input wire [NRAIL-1:0] i_rail_enable_in,
   input wire [NRAIL*16-1:0] i_vout_meas,
   input wire [NRAIL*16-1:0] i_summed_phase_current,
   input wire [NRAIL*NPH-1:0] i_phase_pwm,
   input wire [NRAIL*NPH-1:0] i_phase_oc,
   input wire [NRAIL*NPH-1:0] i_stage_current_monitor_ovr,
   input wire [NRAIL-1:0] i_sense_open,
   input wire [NRAIL*16-1:0] i_temp_meas,
   output wire [NRAIL*NPH-1:0] o_pwm_out,
   output wire [NRAIL*NPH-1:0] o_pwm_oe,
   output wire [NRAIL*NPH-1:0] o_low_side_switch,
   output wire [NRAIL*16-1:0] o_vout_target,
   output wire [NRAIL-1:0] o_rail_good_out_oe,
   output wire o_thermal_warning_out_oe,
   output wire o_alert_line_oe,
   output wire [2:0] o_cfg_id,
   output wire o_telemetry_run
);
   // ****************************************************************
   // init and configuration selection
   // ****************************************************************
   localparam [1:0] P_LOAD = 2'd0;
   localparam [1:0] P_WAIT = 2'd1;
   localparam [1:0] P_RUN = 2'd2;
   reg [1:0] por_reg;
   reg [2:0] cfg_id_reg;
   reg tele_reg;
   reg [3:0] save_cnt_reg;
   reg [7:0] slot_valid_reg;
   reg [7:0] slot_cnt_reg [0:7];
   // map select resistance code to identifier (6800 ohm code is 0)
   function [2:0] cfg_map;
      input [2:0] code;
      begin
         cfg_map = code; // see RQ7
      end
   endfunction
   // power on: catch strap after release, start telemetry
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         por_reg <= P_LOAD;
         cfg_id_reg <= 3'h0;
         tele_reg <= 1'b0;
      end
      else
      begin
         case (por_reg)
            P_LOAD:
            begin
               cfg_id_reg <= cfg_map(i_cfg_sel_code); // see RQ1
               tele_reg <= 1'b1; // see RQ1
               por_reg <= P_WAIT;
            end
            P_WAIT:
               if (i_input_voltage_ok)
                  por_reg <= P_RUN; // see RQ2
            P_RUN:
               if (!i_input_voltage_ok)
                  por_reg <= P_WAIT;
            default:
               por_reg <= P_LOAD;
         endcase
      end
   end
   assign o_cfg_id = cfg_id_reg;
   assign o_telemetry_run = tele_reg;
   // ****************************************************************
   // register file
   // ****************************************************************
   reg [31:0] ctrl_reg;
   reg [7:0] fen_reg;
   reg [7:0] fretry_reg;
   reg [7:0] pgmask_reg;
   reg [15:0] ovth_reg;
   reg [15:0] uvth_reg;
   reg [15:0] ocfth_reg;
   reg [15:0] ocsth_reg;
   reg [31:0] tempth_reg;
   reg [31:0] delay_reg;
   reg [15:0] ramp_reg;
   reg [7:0] pkcnt_reg;
   reg [31:0] nvm_reg;
   reg aw_reg;
   reg w_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   wire [NRAIL*4-1:0] rail_state;
   wire [NRAIL*8-1:0] rail_flt;
   wire [NRAIL-1:0] rail_good;
   wire [NRAIL-1:0] rail_alert;
   wire [NRAIL-1:0] rail_tw;
   wire do_wr;
   wire flt_clr;
   integer i;
   assign o_s_axi_awready = !aw_reg && !bvalid_reg;
   assign o_s_axi_wready = !w_reg && !bvalid_reg;
   assign do_wr = aw_reg && w_reg && !bvalid_reg;
   assign flt_clr = do_wr && (awaddr_reg == `RSFM_FLT);
   // byte lane merge
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1)
            if (st[b])
               merge[b*8 +: 8] = nw[b*8 +: 8];
      end
   endfunction
   // write channel: take address and data in either order
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'b00;
         ctrl_reg <= `RSFM_CTRL_RST;
         fen_reg <= `RSFM_FEN_RST; // see RQ9
         fretry_reg <= `RSFM_FRETRY_RST;
         pgmask_reg <= `RSFM_PGMASK_RST;
         ovth_reg <= 16'hFFFF;
         uvth_reg <= 16'h0000;
         ocfth_reg <= 16'hFFFF;
         ocsth_reg <= 16'hFFFF;
         tempth_reg <= 32'hFFFF_FFFF;
         delay_reg <= 32'h0000_0000;
         ramp_reg <= 16'h0000;
         pkcnt_reg <= 8'h00;
         nvm_reg <= 32'h0000_0000;
         save_cnt_reg <= 4'h0;
         slot_valid_reg <= 8'h00;
         for (i = 0; i < 8; i = i + 1)
            slot_cnt_reg[i] <= 8'h00;
      end
      else
      begin
         if (i_s_axi_awvalid && o_s_axi_awready)
         begin
            aw_reg <= 1'b1;
            awaddr_reg <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready)
         begin
            w_reg <= 1'b1;
            wdata_reg <= i_s_axi_wdata;
            wstrb_reg <= i_s_axi_wstrb;
         end
         if (bvalid_reg && i_s_axi_bready)
            bvalid_reg <= 1'b0;
         if (do_wr)
         begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= 2'b00;
            case (awaddr_reg)
               `RSFM_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
               `RSFM_FEN: fen_reg <= wdata_reg[7:0];
               `RSFM_FRETRY: fretry_reg <= wdata_reg[7:0];
               `RSFM_PGMASK: pgmask_reg <= wdata_reg[7:0];
               `RSFM_OVTH: ovth_reg <= wdata_reg[15:0];
               `RSFM_UVTH: uvth_reg <= wdata_reg[15:0];
               `RSFM_OCFTH: ocfth_reg <= wdata_reg[15:0];
               `RSFM_OCSTH: ocsth_reg <= wdata_reg[15:0];
               `RSFM_TEMPTH: tempth_reg <= merge(tempth_reg, wdata_reg,
                  wstrb_reg);
               `RSFM_DELAY: delay_reg <= merge(delay_reg, wdata_reg,
                  wstrb_reg);
               `RSFM_RAMP: ramp_reg <= wdata_reg[15:0];
               `RSFM_PKCNT: pkcnt_reg <= wdata_reg[7:0];
               `RSFM_FLT: bresp_reg <= 2'b00;
               `RSFM_NVMCMD:
               begin
                  // save: newest per id wins, eight saves total
                  if (save_cnt_reg < `RSFM_NSLOT)
                  begin
                     save_cnt_reg <= save_cnt_reg + 4'h1; // see RQ8
                     slot_valid_reg[wdata_reg[2:0]] <= 1'b1;
                     slot_cnt_reg[wdata_reg[2:0]] <= {4'h0, save_cnt_reg};
                  end
                  else
                     bresp_reg <= 2'b10; // see RQ8
                  nvm_reg <= wdata_reg;
               end
               `RSFM_STAT, `RSFM_CFGSTAT: bresp_reg <= 2'b00;
               default: bresp_reg <= 2'b10;
            endcase
         end
      end
   end
   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp = bresp_reg;
   // read channel: one cycle to data
   assign o_s_axi_arready = !rvalid_reg;
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'b00;
      end
      else if (rvalid_reg)
      begin
         if (i_s_axi_rready)
            rvalid_reg <= 1'b0;
      end
      else if (i_s_axi_arvalid)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= 2'b00;
         case (i_s_axi_araddr)
            `RSFM_CTRL: rdata_reg <= ctrl_reg;
            `RSFM_FEN: rdata_reg <= {24'h0, fen_reg};
            `RSFM_FRETRY: rdata_reg <= {24'h0, fretry_reg};
            `RSFM_PGMASK: rdata_reg <= {24'h0, pgmask_reg};
            `RSFM_OVTH: rdata_reg <= {16'h0, ovth_reg};
            `RSFM_UVTH: rdata_reg <= {16'h0, uvth_reg};
            `RSFM_OCFTH: rdata_reg <= {16'h0, ocfth_reg};
            `RSFM_OCSTH: rdata_reg <= {16'h0, ocsth_reg};
            `RSFM_TEMPTH: rdata_reg <= tempth_reg;
            `RSFM_DELAY: rdata_reg <= delay_reg;
            `RSFM_RAMP: rdata_reg <= {16'h0, ramp_reg};
            `RSFM_PKCNT: rdata_reg <= {24'h0, pkcnt_reg};
            `RSFM_STAT: rdata_reg <= {16'h0, rail_state[7:0], 2'b00,
               rail_tw, rail_good, 2'b00};
            `RSFM_FLT: rdata_reg <= {16'h0, rail_flt[15:0]};
            `RSFM_CFGSTAT: rdata_reg <= {12'h0, slot_valid_reg,
               save_cnt_reg, 1'b0, tele_reg, por_reg, 1'b0, cfg_id_reg};
            `RSFM_NVMCMD: rdata_reg <= nvm_reg;
            default:
            begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= 2'b10;
            end
         endcase
      end
   end
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;
   // ****************************************************************
   // per rail sequencer and fault logic
   // ****************************************************************
   localparam [3:0] S_OFF = 4'd0;
   localparam [3:0] S_INIT = 4'd1;
   localparam [3:0] S_DLY = 4'd2;
   localparam [3:0] S_RAMP = 4'd3;
   localparam [3:0] S_ON = 4'd4;
   localparam [3:0] S_FLT = 4'd5;
   localparam [3:0] S_DOWN = 4'd6;
   localparam [3:0] S_SUSP = 4'd7;
   wire sys_ok;
   assign sys_ok = (por_reg == P_RUN);
   genvar r;
   generate
      for (r = 0; r < NRAIL; r = r + 1)
      begin : g_rail // see RQ23
         reg [3:0] st_reg;
         reg [3:0] st_next;
         reg [31:0] cnt_reg;
         reg [15:0] tgt_reg;
         reg [7:0] flt_reg;
         reg [7:0] pk_reg [0:NPH-1];
         reg soft_done_reg;
         reg [7:0] slow_reg;
         wire [15:0] vm = i_vout_meas[r*16 +: 16];
         wire [15:0] im = i_summed_phase_current[r*16 +: 16];
         wire [15:0] tm = i_temp_meas[r*16 +: 16];
         wire [15:0] vset = ctrl_reg[15:0];
         wire act = (st_reg == S_RAMP) || (st_reg == S_ON);
         wire [7:0] raw;
         wire [7:0] evt;
         wire kill;
         wire [NPH-1:0] pk_over;
         // digital compares on the voltage, current and temperature measurements
         assign raw[`RSFM_F_OV] = act && (vm > ovth_reg); // see RQ12
         assign raw[`RSFM_F_UV] = (st_reg == S_ON) && (vm < uvth_reg);
         assign raw[`RSFM_F_OCF] = act && (im > ocfth_reg); // see RQ17
         assign raw[`RSFM_F_OCS] = act && (slow_reg == 8'hFF);
         assign raw[`RSFM_F_PK] = act && (|pk_over); // see RQ19
         assign raw[`RSFM_F_SPS] = act &&
            (|i_stage_current_monitor_ovr[r*NPH +: NPH]); // see RQ20
         assign raw[`RSFM_F_OT] = act && (tm > tempth_reg[31:16]);
         assign raw[`RSFM_F_TW] = act && (tm > tempth_reg[15:0]); // see RQ22
         assign evt = raw & fen_reg; // see RQ9
         // warning never shuts the rail down
         assign kill = |evt[6:0]; // see RQ21
         // per phase: invert pwm on peak and count consecutive cycles
         genvar p;
         for (p = 0; p < NPH; p = p + 1)
         begin : g_ph
            wire oc = i_phase_oc[r*NPH + p];
            assign pk_over[p] = (pkcnt_reg != 8'h00) &&
               (pk_reg[p] >= pkcnt_reg);
            always @(posedge i_sys_clk)
            begin
               if (i_rst || !act)
                  pk_reg[p] <= 8'h00;
               else if (!oc)
                  pk_reg[p] <= 8'h00;
               else if (pk_reg[p] != 8'hFF)
                  pk_reg[p] <= pk_reg[p] + 8'h01;
            end
            assign o_pwm_out[r*NPH + p] = i_phase_pwm[r*NPH + p] ^
               (oc && act); // see RQ18
            assign o_pwm_oe[r*NPH + p] = act; // see RQ3
            assign o_low_side_switch[r*NPH + p] = (st_reg == S_FLT) &&
               flt_reg[`RSFM_F_OV] && (vm > ovth_reg) &&
               cnt_reg[3]; // see RQ13
         end
         // sequencer next state
         always @*
         begin
            st_next = st_reg;
            case (st_reg)
               S_OFF:
                  if (sys_ok && i_rail_enable_in[r])
                     st_next = S_INIT; // see RQ2
               S_INIT:
                  if (!i_rail_enable_in[r])
                     st_next = S_OFF;
                  else if (cnt_reg >= INIT_CYC - 1)
                     st_next = S_DLY; // see RQ5
               S_DLY:
                  if (!i_rail_enable_in[r])
                     st_next = S_OFF;
                  else if (cnt_reg >= delay_reg[15:0])
                     st_next = S_RAMP; // see RQ4
               S_RAMP, S_ON:
                  if (i_sense_open[r])
                     st_next = S_SUSP; // see RQ16
                  else if (kill)
                     st_next = S_FLT; // see RQ13 RQ14
                  else if (!i_rail_enable_in[r] || !sys_ok)
                     st_next = S_DOWN;
                  else if (st_reg == S_RAMP && tgt_reg == vset)
                     st_next = S_ON;
               S_DOWN:
                  if (tgt_reg == 16'h0000)
                     st_next = S_OFF;
               S_FLT:
                  if (!i_rail_enable_in[r])
                     st_next = S_OFF; // see RQ15
                  else if ((flt_reg & fretry_reg) != 8'h00 &&
                     cnt_reg >= delay_reg[31:16])
                     st_next = S_INIT; // see RQ9
               S_SUSP:
                  if (!i_sense_open[r])
                     st_next = S_OFF;
               default:
                  st_next = S_OFF;
            endcase
         end
         // state, counter, target ramp, fault latches
         always @(posedge i_sys_clk)
         begin
            if (i_rst)
            begin
               st_reg <= S_OFF;
               cnt_reg <= 32'h0000_0000;
               tgt_reg <= 16'h0000;
               flt_reg <= 8'h00;
               soft_done_reg <= 1'b0;
               slow_reg <= 8'h00;
            end
            else
            begin
               st_reg <= st_next;
               cnt_reg <= (st_next != st_reg) ? 32'h0000_0000 :
                  cnt_reg + 32'h0000_0001;
               // slow path: integrate time above threshold
               if (act && im > ocsth_reg)
                  slow_reg <= (slow_reg == 8'hFF) ? slow_reg :
                     slow_reg + 8'h01; // see RQ17
               else
                  slow_reg <= 8'h00;
               soft_done_reg <= (st_next == S_ON); // see RQ10
               // ramp: one step per cycle, straight to target after ramp_reg cycles, zero steps at once
               if (st_reg == S_RAMP && (ramp_reg == 16'h0000 ||
                  cnt_reg[15:0] >= ramp_reg))
                  tgt_reg <= vset; // see RQ6
               else if (st_reg == S_RAMP && tgt_reg != vset)
                  tgt_reg <= (tgt_reg < vset) ? tgt_reg + 16'h0001 :
                     tgt_reg - 16'h0001; // see RQ4
               else if (st_reg == S_DOWN)
                  tgt_reg <= (ramp_reg == 16'h0000 || tgt_reg == 16'h0000)
                     ? 16'h0000 : tgt_reg - 16'h0001;
               else if (st_reg != S_ON)
                  tgt_reg <= 16'h0000;
               // set wins over software clear
               if (flt_clr && r < 2)
                  flt_reg <= evt | (flt_reg & ~wdata_reg[r*8 +: 8]);
               else
                  flt_reg <= flt_reg | evt;
            end
         end
         assign o_vout_target[r*16 +: 16] = tgt_reg;
         assign rail_state[r*4 +: 4] = st_reg;
         assign rail_flt[r*8 +: 8] = flt_reg;
         assign rail_good[r] = soft_done_reg && (st_reg == S_ON) &&
            (vm <= ovth_reg) && (vm >= uvth_reg) &&
            ((raw & pgmask_reg) == 8'h00); // see RQ10 RQ11 RQ22
         assign rail_alert[r] = |(flt_reg[6:0]); // see RQ13 RQ14
         assign rail_tw[r] = (st_reg != S_OFF) &&
            evt[`RSFM_F_TW]; // see RQ21
         assign o_rail_good_out_oe[r] = !rail_good[r];
      end
   endgenerate
   assign o_alert_line_oe = |rail_alert;
   assign o_thermal_warning_out_oe = |rail_tw;
endmodule // rsfm_top

// ### rtl/rsfm_regs.vh
// rsfm_regs.vh: register map, fields, reset values and timing counts
// for the rail sequencing and fault manager; include by bare name
`ifndef RSFM_REGS_VH
`define RSFM_REGS_VH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define RSFM_CTRL 8'h00
`define RSFM_FEN 8'h04
`define RSFM_FRETRY 8'h08
`define RSFM_PGMASK 8'h0C
`define RSFM_OVTH 8'h10
`define RSFM_UVTH 8'h14
`define RSFM_OCFTH 8'h18
`define RSFM_OCSTH 8'h1C
`define RSFM_TEMPTH 8'h20
`define RSFM_DELAY 8'h24
`define RSFM_RAMP 8'h28
`define RSFM_PKCNT 8'h2C
`define RSFM_STAT 8'h30
`define RSFM_FLT 8'h34
`define RSFM_CFGSTAT 8'h38
`define RSFM_NVMCMD 8'h3C
// ****************************************************************
// fault bit positions
// ****************************************************************
`define RSFM_F_OV 0
`define RSFM_F_UV 1
`define RSFM_F_OCF 2
`define RSFM_F_OCS 3
`define RSFM_F_PK 4
`define RSFM_F_SPS 5
`define RSFM_F_OT 6
`define RSFM_F_TW 7
`define RSFM_NF 8
// ****************************************************************
// reset values
// ****************************************************************
`define RSFM_FEN_RST 8'hFF
`define RSFM_FRETRY_RST 8'h00
`define RSFM_PGMASK_RST 8'h7F
`define RSFM_CTRL_RST 32'h0000_0000
// ****************************************************************
// timing: init time after enable in ns, cycles at 25 ns period
// ****************************************************************
`define RSFM_INIT_NS 200000
`define RSFM_CLK_NS 25
`define RSFM_INIT_CYC ((`RSFM_INIT_NS + `RSFM_CLK_NS - 1) / `RSFM_CLK_NS)
`define RSFM_NSLOT 8
`endif

// ### sim/rsfm_sva.sv
// rsfm_sva.sv: port checker for the rail sequencer, rail 0 only
// assumes select code steady over reset and phases 0..1 on rail 0
`timescale 1ns/10ps
module rsfm_sva #(
   parameter NRAIL = 2,
   parameter NPH = 2,
   parameter INIT_CYC = 8
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire [2:0] i_cfg_sel_code,
   input wire [NRAIL-1:0] i_rail_enable_in,
   input wire [NRAIL*NPH-1:0] i_phase_pwm,
   input wire [NRAIL*NPH-1:0] i_phase_oc,
   input wire [NRAIL*NPH-1:0] i_stage_current_monitor_ovr,
   input wire [NRAIL*NPH-1:0] o_pwm_out,
   input wire [NRAIL*NPH-1:0] o_pwm_oe,
   input wire [NRAIL*NPH-1:0] o_low_side_switch,
   input wire [NRAIL-1:0] o_rail_good_out_oe,
   input wire o_alert_line_oe,
   input wire [2:0] o_cfg_id
);
// ****************************************************************
// rail 0 properties, init count of 8 as run in sim
// ****************************************************************
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_rst);
shut_hiz_a: assert property (!i_rail_enable_in[0] [*3] |->
   o_pwm_oe[1:0] == 2'h0) else $error("phase driven in shutdown");
init_wait_a: assert property ($rose(o_pwm_oe[0]) |->
   $past(i_rail_enable_in[0], 8)) else $error("ramp before init");
good_off_a: assert property (!o_pwm_oe[0] |->
   o_rail_good_out_oe[0]) else $error("good while not running");
pk_invert_a: assert property (o_pwm_oe[0] |->
   o_pwm_out[0] == (i_phase_pwm[0] ^ i_phase_oc[0]))
   else $error("peak limit pwm wrong");
lsw_off_a: assert property (o_low_side_switch[0] |->
   !o_pwm_oe[0] && o_alert_line_oe && o_rail_good_out_oe[0])
   else $error("low side pulse while running");
sps_trip_a: assert property (o_pwm_oe[0] &&
   i_stage_current_monitor_ovr[0] |-> ##[1:3] !o_pwm_oe[0])
   else $error("stage overcurrent ignored");
en_drop_a: assert property ($fell(i_rail_enable_in[0]) |->
   ##[1:3] !o_pwm_oe[0]) else $error("rail kept after enable low");
cfg_id_a: assert property ($fell(i_rst) |-> ##[1:4]
   o_cfg_id == i_cfg_sel_code) else $error("config id wrong");
endmodule // rsfm_sva
bind rsfm_top rsfm_sva #(.NRAIL(NRAIL), .NPH(NPH), .INIT_CYC(INIT_CYC))
   u_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_cfg_sel_code(i_cfg_sel_code), .i_rail_enable_in(i_rail_enable_in),
   .i_phase_pwm(i_phase_pwm), .i_phase_oc(i_phase_oc),
   .i_stage_current_monitor_ovr(i_stage_current_monitor_ovr),
   .o_pwm_out(o_pwm_out), .o_pwm_oe(o_pwm_oe),
   .o_low_side_switch(o_low_side_switch), .o_cfg_id(o_cfg_id),
   .o_rail_good_out_oe(o_rail_good_out_oe),
   .o_alert_line_oe(o_alert_line_oe));

// ### sim/rsfm_stage.sv
// rsfm_stage.sv: power stage and output filter model, both rails
// assumes enables and targets come straight from the sequencer
`timescale 1ns/10ps
module rsfm_stage #(
   parameter NRAIL = 2,
   parameter NPH = 2
) (
   input wire i_sys_clk,
   input wire [NRAIL*NPH-1:0] i_pwm_oe,
   input wire [NRAIL*16-1:0] i_vout_target,
   input wire [NRAIL*16-1:0] i_vout_bump,
   output reg [NRAIL*16-1:0] o_vout_meas = 0
);
integer r;
// output tracks target while driven; overshoot holds charge
always @(posedge i_sys_clk)
begin
   for (r = 0; r < NRAIL; r = r + 1)
      if (|i_pwm_oe[r*NPH +: NPH])
         o_vout_meas[r*16 +: 16] <= i_vout_target[r*16 +: 16] +
            i_vout_bump[r*16 +: 16];
      else if (i_vout_bump[r*16 +: 16] == 16'h0000)
         o_vout_meas[r*16 +: 16] <= o_vout_meas[r*16 +: 16] >> 1;
end
endmodule // rsfm_stage

// ### sim/rsfm_top_tb.sv
// rsfm_top_tb.sv: register and sequencing tests of rsfm_top, rail 0
// assumes the stage model closes the output voltage loop
`timescale 1ns/10ps
`include "rsfm_regs.vh"
module rsfm_top_tb;
reg clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
reg arv = 1'b0, rrdy = 1'b0;
reg [7:0] awa = 8'h00, ara = 8'h00;
reg [31:0] wd = 32'h0000_0000, temp = 32'h0000_0000, bump = 0;
reg [1:0] en = 2'h0, rs, sop = 2'h0;
reg [3:0] ppwm = 4'h0, poc = 4'h0, povr = 4'h0;
wire awr, wr_rdy, bv, arr, rv, tw, alert, tel;
wire [1:0] br, rr, good;
wire [31:0] rdat, vtgt, vm;
wire [3:0] pwm, oe, lsw;
wire [2:0] cid;
integer mismatches = 0, cmp_count = 0, i, n;
reg [31:0] d;
// ****************************************************************
// design, stage model and clock
// ****************************************************************
rsfm_top #(.INIT_CYC(8)) uut (.i_sys_clk(clk), .i_rst(rst),
   .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
   .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
   .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
   .i_s_axi_bready(brdy), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
   .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr),
   .o_s_axi_rvalid(rv), .i_s_axi_rready(rrdy), .i_cfg_sel_code(3'h5),
   .i_input_voltage_ok(1'b1), .i_rail_enable_in(en), .i_vout_meas(vm),
   .i_summed_phase_current(32'h0000_0000), .i_phase_pwm(ppwm),
   .i_phase_oc(poc), .i_stage_current_monitor_ovr(povr),
   .i_sense_open(sop), .i_temp_meas(temp), .o_pwm_out(pwm),
   .o_pwm_oe(oe), .o_low_side_switch(lsw), .o_vout_target(vtgt),
   .o_rail_good_out_oe(good), .o_thermal_warning_out_oe(tw),
   .o_alert_line_oe(alert), .o_cfg_id(cid), .o_telemetry_run(tel));
rsfm_stage u_stage (.i_sys_clk(clk), .i_pwm_oe(oe),
   .i_vout_target(vtgt), .i_vout_bump(bump), .o_vout_meas(vm));
// free running clock
always #12.5 clk = ~clk;
task chk(input [39:0] got, input [39:0] exp);
begin
   cmp_count = cmp_count + 1;
   if (got !== exp)
   begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
   end
end
endtask
// write: ready sampled mid cycle, released at the taking edge
task wr(input [7:0] a, input [31:0] v, output [1:0] r);
reg ta, tw2, tb;
begin
   @(posedge clk);
   awa <= a;
   wd <= v;
   awv <= 1'b1;
   wv <= 1'b1;
   brdy <= 1'b1;
   tb = 1'b0;
   while (!tb)
   begin
      @(negedge clk);
      ta = awr & awv;
      tw2 = wr_rdy & wv;
      tb = bv;
      r = br;
      @(posedge clk);
      if (ta)
         awv <= 1'b0;
      if (tw2)
         wv <= 1'b0;
   end
   brdy <= 1'b0;
end
endtask
task rd(input [7:0] a, output [31:0] v, output [1:0] r);
reg ta, tb;
begin
   @(posedge clk);
   ara <= a;
   arv <= 1'b1;
   rrdy <= 1'b1;
   tb = 1'b0;
   while (!tb)
   begin
      @(negedge clk);
      ta = arr & arv;
      tb = rv;
      v = rdat;
      r = rr;
      @(posedge clk);
      if (ta)
         arv <= 1'b0;
   end
   rrdy <= 1'b0;
end
endtask
// enable rail 0 and wait for good, counting cycles
task up;
begin
   @(posedge clk);
   en <= 2'h1;
   n = 0;
   while (good[0] !== 1'b0 && n < 400)
   begin
      @(negedge clk);
      n = n + 1;
   end
   chk(n > 11 && n < 400, 1'b1);
   chk({oe[1:0], vtgt[15:0]}, 18'h3_0400);
end
endtask
task recover;
begin
   wr(`RSFM_FLT, 32'h0000_ffff, rs);
   @(posedge clk);
   en <= 2'h0;
   repeat (3) @(posedge clk);
   up;
end
endtask
task settle(input integer c);
begin
   repeat (c) @(posedge clk);
   @(negedge clk);
end
endtask
task close_out;
begin
   $display("mismatches %0d compares %0d", mismatches, cmp_count);
   if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
end
endtask
// watchdog against a hung handshake or sequence
initial
begin
   repeat (20000) @(posedge clk);
   mismatches = mismatches + 1;
   close_out;
end
// ****************************************************************
// test sequence
// ****************************************************************
initial
begin
   repeat (16) @(posedge clk);
   rst <= 1'b0;
   settle(4);
   chk({cid, tel, oe[1:0], good[0]}, 7'h59);
   rd(`RSFM_FEN, d, rs);
   chk(d, `RSFM_FEN_RST);
   rd(`RSFM_PGMASK, d, rs);
   chk(d, `RSFM_PGMASK_RST);
   rd(8'h40, d, rs);
   chk({rs, d}, 34'h2_0000_0000);
   for (i = 0; i < 9; i = i + 1)
      wr(`RSFM_NVMCMD, i % 8, rs);
   chk(rs, 2'h2);
   rd(`RSFM_CFGSTAT, d, rs);
   chk({d[19:8], d[2:0]}, 15'h7fc5);
   wr(`RSFM_CTRL, 32'h0000_0400, rs);
   wr(`RSFM_OVTH, 32'h0000_0500, rs);
   wr(`RSFM_UVTH, 32'h0000_0200, rs);
   wr(`RSFM_TEMPTH, 32'hf000_0100, rs);
   wr(`RSFM_DELAY, 32'h0000_0004, rs);
   wr(`RSFM_RAMP, 32'h0000_0004, rs);
   up;
   @(posedge clk) poc <= 4'h1;
   settle(3);
   chk({pwm[0], oe[1:0]}, 3'h7);
   @(posedge clk) poc <= 4'h0;
   temp <= 32'h0000_0200;
   settle(4);
   chk({tw, oe[1:0]}, 3'h7);
   @(posedge clk) temp <= 32'h0000_0000;
   bump <= 32'h0000_0200;
   settle(6);
   chk({oe[1:0], good[0], alert}, 4'h3);
   for (i = 0; i < 40 && lsw[0] !== 1'b1; i = i + 1)
      @(negedge clk);
   chk(lsw[0], 1'b1);
   @(posedge clk);
   bump <= 32'h0000_0000;
   settle(40);
   chk({oe[1:0], lsw[0]}, 3'h0);
   rd(`RSFM_FLT, d, rs);
   chk(d[0], 1'b1);
   recover;
   @(posedge clk) povr <= 4'h1;
   settle(4);
   chk(oe[1:0], 2'h0);
   @(posedge clk) povr <= 4'h0;
   rd(`RSFM_FLT, d, rs);
   chk(d[5], 1'b1);
   recover;
   @(posedge clk) sop <= 2'h1;
   settle(3);
   chk({oe[1:0], good[0]}, 3'h1);
   close_out;
end
endmodule // rsfm_top_tb
